//--- rtl/scl_pkg.sv
package scl_pkg;

   // ==========================================================================
   // Register map
   localparam logic [4:0]  CFG_REG_ADDR      = 5'h1e;
   localparam logic [15:0] CFG_REG_RESET     = 16'h0000;
   localparam int          CFG_BIT_LOW_RATE  = 8;
   localparam int          CFG_BIT_FIXED     = 9;
   localparam int          CFG_BIT_ADV_FD    = 10;
   localparam int          CFG_BIT_PASS_OFF  = 11;
   localparam int          CFG_BIT_AN_OFF    = 14;
   localparam int          CFG_BIT_ADV_HD    = 15;
   localparam int          CFG_BIT_SHORT_FO  = 5;
   localparam int          CFG_BIT_LONG_WL   = 6;
   localparam int          CFG_BIT_FIBER_IF  = 7;

   // ==========================================================================
   // Strap timing
   localparam int STRAP_SETTLE_NS = 2000;
   localparam int CLK_FREQ_MHZ    = 125;
   localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int SETTLE_CNT_W     = 8;
   localparam logic [SETTLE_CNT_W-1:0] SETTLE_LAST =
      SETTLE_CNT_W'(STRAP_SETTLE_CYC - 1);
   localparam logic [SETTLE_CNT_W-1:0] SETTLE_CNT_RESET = 8'h00;

   // ==========================================================================
   // Strap levels
   typedef enum logic [1:0] {
      LVL_GND = 2'h0,
      LVL_MID = 2'h1,
      LVL_VCC = 2'h2
   } scl_lvl_e;

   typedef enum logic [1:0] {
      FIB_GND      = 2'h0,
      FIB_THIRD    = 2'h1,
      FIB_TWOTHIRD = 2'h2,
      FIB_VCC      = 2'h3
   } scl_fib_e;

   // ==========================================================================
   // Loader states and operating modes
   typedef enum logic [2:0] {
      ST_SETTLE = 3'b001,
      ST_LOAD   = 3'b010,
      ST_RUN    = 3'b100
   } scl_state_e;

   typedef enum logic [4:0] {
      MODE_FORCED_10   = 5'b00001,
      MODE_FORCED_100  = 5'b00010,
      MODE_HALF_ONLY   = 5'b00100,
      MODE_BOTH_DUPLEX = 5'b01000,
      MODE_PASSTHROUGH = 5'b10000
   } scl_mode_e;

   localparam scl_mode_e MODE_RESET = MODE_BOTH_DUPLEX;

endpackage : scl_pkg

//--- rtl/scl_strap_if.sv
`timescale 1ns/1ps

interface scl_strap_if;
   import scl_pkg::*;

   // Index 0 is the duplex strap, index 1 the rate strap.
   logic [1:0] cmp [2];
   scl_lvl_e   lvl [2];

   modport loader  (output cmp, input lvl);
   modport decoder (input cmp, output lvl);

endinterface : scl_strap_if

//--- rtl/scl_strap_decode.sv
`timescale 1ns/1ps

module scl_strap_decode
   import scl_pkg::*;
(
   scl_strap_if.decoder s
);

   // ==========================================================================
   // Three level resolve
   // Bit 0 is the quarter-supply comparator, bit 1 the three-quarter one.
   // An open pin floats to mid supply through the internal divider.
   // A torn code with only the upper comparator set is treated as mid, the
   // same answer an open pin gives.
   for (genvar g = 0; g < 2; g++) begin : g_res
      always_comb begin
         unique case (s.cmp[g])
            2'b00:   s.lvl[g] = LVL_GND;
            2'b11:   s.lvl[g] = LVL_VCC;
            default: s.lvl[g] = LVL_MID;
         endcase
      end
   end

endmodule : scl_strap_decode

//--- rtl/scl_loader.sv
// Notes on behaviour
// - Fiber strap at third sets bit 7.
// - Fiber strap at supply sets bit 5.
// - Fiber strap at two-thirds sets bit 6.
// - Fiber strap at ground clears bits 7..5.
// - Management writes retune quantizer via bits 7..5.
// - Short fiber raises signal detect thresholds.
// - Duplex strap loads bits 11, 10, 15.
// - Rate strap loads bits 14, 9, 8.
// - Duplex and rate straps resolve three levels.
// - Management writes override strap defaults.
// - Straps sampled once microseconds after power-up.
// - Mode follows the stored word, so management writes move it too.
// - Rate forces speed; mid rate uses duplex.
`timescale 1ns/1ps

module scl_loader
   import scl_pkg::*;
(
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic [1:0]  fiber_if_strap,
   input  wire logic [1:0]  duplex_strap_cmp,
   input  wire logic [1:0]  rate_strap_cmp,
   input  wire logic [4:0]  mgmt_addr,
   input  wire logic        mgmt_wr_en,
   input  wire logic [15:0] mgmt_wdata,
   input  wire logic        mgmt_rd_en,
   output logic      [15:0] mgmt_rdata,
   output logic             mgmt_rd_valid,
   output logic             straps_loaded,
   output logic      [15:0] cfg_word,
   output logic             fiber_if_logic_sel,
   output logic             short_fiber_sel,
   output logic             long_wavelength_sel,
   output logic             sd_thr_raised,
   output logic      [2:0]  quant_sens,
   output logic             passthrough_off,
   output logic             adv_full_dup_off,
   output logic             adv_half_dup_off,
   output logic             autoneg_disable,
   output logic             fixed_rate_sel,
   output logic             low_rate_sel,
   output logic      [4:0]  op_mode
);

   // ==========================================================================
   // State
   typedef struct packed {
      scl_state_e                state;
      logic [SETTLE_CNT_W-1:0]   cnt;
      logic [15:0]               cfg;
      logic [15:0]               rdata;
      logic                      rd_valid;
      logic                      loaded;
      scl_mode_e                 mode;
   } scl_loader_s;

   localparam scl_loader_s LOADER_RESET = '{
      state:    ST_SETTLE,
      cnt:      SETTLE_CNT_RESET,
      cfg:      CFG_REG_RESET,
      rdata:    16'h0000,
      rd_valid: 1'b0,
      loaded:   1'b0,
      mode:     MODE_RESET
   };

   scl_loader_s st_ff;
   scl_loader_s nxt_st;

   // ==========================================================================
   // Strap level resolve
   scl_strap_if strap ();

   assign strap.cmp[0] = duplex_strap_cmp;
   assign strap.cmp[1] = rate_strap_cmp;

   scl_strap_decode u_decode (
      .s (strap.decoder)
   );

   scl_lvl_e duplex_lvl;
   scl_lvl_e rate_lvl;

   assign duplex_lvl = strap.lvl[0];
   assign rate_lvl   = strap.lvl[1];

   // ==========================================================================
   // Strap to default decode
   // Only bits in the mask are loaded from the pins; the other bits of the
   // word keep their stored value, which is still zero at that point.
   logic [15:0] strap_cfg;
   logic [15:0] strap_mask;

   always_comb begin
      strap_cfg  = 16'h0000;
      strap_mask = 16'h0000;
      strap_mask[CFG_BIT_FIBER_IF] = 1'b1;
      strap_mask[CFG_BIT_LONG_WL]  = 1'b1;
      strap_mask[CFG_BIT_SHORT_FO] = 1'b1;
      strap_mask[CFG_BIT_PASS_OFF] = 1'b1;
      strap_mask[CFG_BIT_ADV_FD]   = 1'b1;
      strap_mask[CFG_BIT_ADV_HD]   = 1'b1;
      strap_mask[CFG_BIT_AN_OFF]   = 1'b1;
      strap_mask[CFG_BIT_FIXED]    = 1'b1;
      strap_mask[CFG_BIT_LOW_RATE] = 1'b1;

      unique case (scl_fib_e'(fiber_if_strap))
         FIB_GND: begin
            strap_cfg[CFG_BIT_FIBER_IF] = 1'b0;
            strap_cfg[CFG_BIT_LONG_WL]  = 1'b0;
            strap_cfg[CFG_BIT_SHORT_FO] = 1'b0;
         end
         FIB_THIRD: begin
            strap_cfg[CFG_BIT_FIBER_IF] = 1'b1;
            strap_cfg[CFG_BIT_LONG_WL]  = 1'b0;
            strap_cfg[CFG_BIT_SHORT_FO] = 1'b0;
         end
         FIB_TWOTHIRD: begin
            strap_cfg[CFG_BIT_FIBER_IF] = 1'b0;
            strap_cfg[CFG_BIT_LONG_WL]  = 1'b1;
            strap_cfg[CFG_BIT_SHORT_FO] = 1'b0;
         end
         FIB_VCC: begin
            strap_cfg[CFG_BIT_FIBER_IF] = 1'b0;
            strap_cfg[CFG_BIT_LONG_WL]  = 1'b0;
            strap_cfg[CFG_BIT_SHORT_FO] = 1'b1;
         end
      endcase

      unique case (duplex_lvl)
         LVL_GND: begin
            strap_cfg[CFG_BIT_PASS_OFF] = 1'b1;
            strap_cfg[CFG_BIT_ADV_FD]   = 1'b1;
            strap_cfg[CFG_BIT_ADV_HD]   = 1'b0;
         end
         LVL_MID: begin
            strap_cfg[CFG_BIT_PASS_OFF] = 1'b0;
            strap_cfg[CFG_BIT_ADV_FD]   = 1'b0;
            strap_cfg[CFG_BIT_ADV_HD]   = 1'b0;
         end
         LVL_VCC: begin
            strap_cfg[CFG_BIT_PASS_OFF] = 1'b1;
            strap_cfg[CFG_BIT_ADV_FD]   = 1'b0;
            strap_cfg[CFG_BIT_ADV_HD]   = 1'b0;
         end
         // An illegal level code loads the open-pin values.
         default: begin
            strap_cfg[CFG_BIT_PASS_OFF] = 1'b0;
            strap_cfg[CFG_BIT_ADV_FD]   = 1'b0;
            strap_cfg[CFG_BIT_ADV_HD]   = 1'b0;
         end
      endcase

      unique case (rate_lvl)
         LVL_GND: begin
            strap_cfg[CFG_BIT_AN_OFF]   = 1'b1;
            strap_cfg[CFG_BIT_FIXED]    = 1'b1;
            strap_cfg[CFG_BIT_LOW_RATE] = 1'b1;
         end
         LVL_MID: begin
            strap_cfg[CFG_BIT_AN_OFF]   = 1'b0;
            strap_cfg[CFG_BIT_FIXED]    = 1'b0;
            strap_cfg[CFG_BIT_LOW_RATE] = 1'b0;
         end
         LVL_VCC: begin
            strap_cfg[CFG_BIT_AN_OFF]   = 1'b1;
            strap_cfg[CFG_BIT_FIXED]    = 1'b1;
            strap_cfg[CFG_BIT_LOW_RATE] = 1'b0;
         end
         // An illegal level code loads the open-pin values.
         default: begin
            strap_cfg[CFG_BIT_AN_OFF]   = 1'b0;
            strap_cfg[CFG_BIT_FIXED]    = 1'b0;
            strap_cfg[CFG_BIT_LOW_RATE] = 1'b0;
         end
      endcase
   end

   // ==========================================================================
   // Operating mode from the register contents
   // The mode is read back from the stored bits rather than the pins, so a
   // management override moves the mode with it and pins that wander later
   // have no say.
   function automatic scl_mode_e mode_of(input logic [15:0] c);
      scl_mode_e m;
      if (c[CFG_BIT_FIXED]) begin
         m = c[CFG_BIT_LOW_RATE] ? MODE_FORCED_10 : MODE_FORCED_100;
      end else if (!c[CFG_BIT_PASS_OFF]) begin
         m = MODE_PASSTHROUGH;
      end else if (c[CFG_BIT_ADV_FD]) begin
         m = MODE_HALF_ONLY;
      end else begin
         m = MODE_BOTH_DUPLEX;
      end
      return m;
   endfunction : mode_of

   // ==========================================================================
   // Next state
   logic cfg_hit;

   // Only one register is decoded; every other address reads as zero.
   assign cfg_hit = (mgmt_addr == CFG_REG_ADDR);

   always_comb begin
      nxt_st          = st_ff;
      nxt_st.rd_valid = 1'b0;

      unique case (st_ff.state)
         ST_SETTLE: begin
            // The wait is a fixed count of clocks; a slower clock stretches
            // it, which only adds margin for the straps to settle.
            if (st_ff.cnt == SETTLE_LAST) begin
               nxt_st.state = ST_LOAD;
            end else begin
               nxt_st.cnt = st_ff.cnt + SETTLE_CNT_W'(1);
            end
         end
         ST_LOAD: begin
            // The pins feed only this branch, so later movement on them
            // cannot reach the stored word.
            nxt_st.cfg    = (st_ff.cfg & ~strap_mask) | strap_cfg;
            nxt_st.loaded = 1'b1;
            nxt_st.state  = ST_RUN;
         end
         ST_RUN: begin
            // Writes before the load are dropped, so a host write can never
            // race the one strap sample.
            // management override
            if (mgmt_wr_en && cfg_hit) begin
               nxt_st.cfg = mgmt_wdata;
            end
         end
         default: begin
            nxt_st = LOADER_RESET;
         end
      endcase

      // mode from the stored word
      // Before the load the stored word is still zero, which would decode as
      // passthrough, so the mode keeps its reset value until the straps land.
      if (nxt_st.loaded) begin
         nxt_st.mode = mode_of(nxt_st.cfg);
      end else begin
         nxt_st.mode = MODE_RESET;
      end

      // A read in the cycle of a write returns the old word.
      if (mgmt_rd_en) begin
         nxt_st.rd_valid = 1'b1;
         nxt_st.rdata    = cfg_hit ? st_ff.cfg : 16'h0000;
      end
   end

   // ==========================================================================
   // Registers
   // Reset is synchronous; the settle count starts again on each release.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_ff <= LOADER_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================================
   // Outputs
   // Every output is a bit of the state register, so none of them can
   // glitch while the next word is being formed.
   assign mgmt_rdata          = st_ff.rdata;
   assign mgmt_rd_valid       = st_ff.rd_valid;
   assign straps_loaded       = st_ff.loaded;
   assign cfg_word            = st_ff.cfg;
   assign fiber_if_logic_sel  = st_ff.cfg[CFG_BIT_FIBER_IF];
   assign short_fiber_sel     = st_ff.cfg[CFG_BIT_SHORT_FO];
   assign long_wavelength_sel = st_ff.cfg[CFG_BIT_LONG_WL];
   assign sd_thr_raised       = st_ff.cfg[CFG_BIT_SHORT_FO];
   assign quant_sens          = st_ff.cfg[CFG_BIT_FIBER_IF:CFG_BIT_SHORT_FO];
   assign passthrough_off     = st_ff.cfg[CFG_BIT_PASS_OFF];
   assign adv_full_dup_off    = st_ff.cfg[CFG_BIT_ADV_FD];
   assign adv_half_dup_off    = st_ff.cfg[CFG_BIT_ADV_HD];
   assign autoneg_disable     = st_ff.cfg[CFG_BIT_AN_OFF];
   assign fixed_rate_sel      = st_ff.cfg[CFG_BIT_FIXED];
   assign low_rate_sel        = st_ff.cfg[CFG_BIT_LOW_RATE];
   assign op_mode             = st_ff.mode;

endmodule : scl_loader

//--- verif/scl_loader_asserts.sv
`timescale 1ns/1ps

module scl_loader_asserts
   import scl_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic [1:0]  fiber_if_strap,
   input wire logic [1:0]  duplex_strap_cmp,
   input wire logic [1:0]  rate_strap_cmp,
   input wire logic [4:0]  mgmt_addr,
   input wire logic        mgmt_wr_en,
   input wire logic [15:0] mgmt_wdata,
   input wire logic        mgmt_rd_en,
   input wire logic [15:0] mgmt_rdata,
   input wire logic        mgmt_rd_valid,
   input wire logic        straps_loaded,
   input wire logic [15:0] cfg_word,
   input wire logic        sd_thr_raised,
   input wire logic [2:0]  quant_sens,
   input wire logic [4:0]  op_mode
);
   // ==========================================================================
   // Properties
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   property p_fib;
      $rose(straps_loaded) |-> cfg_word[7:5] == {$past(fiber_if_strap) == 2'h1,
         $past(fiber_if_strap) == 2'h2, $past(fiber_if_strap) == 2'h3};
   endproperty
   a_fib: assert property (p_fib) else $error("fiber defaults wrong");
   property p_dup;
      $rose(straps_loaded) |-> {cfg_word[11], cfg_word[10], cfg_word[15]} ==
         {$past(duplex_strap_cmp) inside {2'h0, 2'h3}, $past(duplex_strap_cmp) == 2'h0, 1'b0};
   endproperty
   a_dup: assert property (p_dup) else $error("duplex defaults wrong");
   property p_rate;
      $rose(straps_loaded) |-> {cfg_word[14], cfg_word[9], cfg_word[8]} ==
         {{2{$past(rate_strap_cmp) inside {2'h0, 2'h3}}}, $past(rate_strap_cmp) == 2'h0};
   endproperty
   a_rate: assert property (p_rate) else $error("rate defaults wrong");
   property p_quant;
      quant_sens == cfg_word[7:5] && sd_thr_raised == cfg_word[5];
   endproperty
   a_quant: assert property (p_quant) else $error("quantizer outputs wrong");
   property p_wr;
      straps_loaded && mgmt_wr_en && mgmt_addr == 5'h1e |=> cfg_word == $past(mgmt_wdata);
   endproperty
   a_wr: assert property (p_wr) else $error("write not applied");
   property p_hold;
      straps_loaded && !(mgmt_wr_en && mgmt_addr == 5'h1e) |=> $stable(cfg_word);
   endproperty
   a_hold: assert property (p_hold) else $error("config changed unasked");
   property p_time;
      $fell(rst) |-> ##250 !straps_loaded ##1 straps_loaded;
   endproperty
   a_time: assert property (p_time) else $error("strap sample time wrong");
   property p_once;
      straps_loaded |=> straps_loaded;
   endproperty
   a_once: assert property (p_once) else $error("load flag dropped");
   property p_mode;
      straps_loaded |-> op_mode == (cfg_word[9] ? (cfg_word[8] ? 5'h01 : 5'h02) :
         !cfg_word[11] ? 5'h10 : cfg_word[10] ? 5'h04 : 5'h08);
   endproperty
   a_mode: assert property (p_mode) else $error("operating mode wrong");
   property p_rd;
      mgmt_rd_en |=> mgmt_rd_valid &&
         mgmt_rdata == ($past(mgmt_addr) == 5'h1e ? $past(cfg_word) : 16'h0000);
   endproperty
   a_rd: assert property (p_rd) else $error("read answer wrong");
   property p_rd_pulse;
      !mgmt_rd_en |=> !mgmt_rd_valid;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse) else $error("read valid too long");
   property p_mode_pre;
      !straps_loaded |-> op_mode == MODE_RESET;
   endproperty
   a_mode_pre: assert property (p_mode_pre) else $error("mode moved before load");
endmodule : scl_loader_asserts

bind scl_loader scl_loader_asserts u_chk (
   .ref_clk          (ref_clk),
   .rst              (rst),
   .fiber_if_strap   (fiber_if_strap),
   .duplex_strap_cmp (duplex_strap_cmp),
   .rate_strap_cmp   (rate_strap_cmp),
   .mgmt_addr        (mgmt_addr),
   .mgmt_wr_en       (mgmt_wr_en),
   .mgmt_wdata       (mgmt_wdata),
   .mgmt_rd_en       (mgmt_rd_en),
   .mgmt_rdata       (mgmt_rdata),
   .mgmt_rd_valid    (mgmt_rd_valid),
   .straps_loaded    (straps_loaded),
   .cfg_word         (cfg_word),
   .sd_thr_raised    (sd_thr_raised),
   .quant_sens       (quant_sens),
   .op_mode          (op_mode)
);

//--- verif/scl_strap_model.sv
`timescale 1ns/1ps

module scl_strap_model (
   input  wire logic [1:0] level,
   input  wire logic       jitter,
   output logic      [1:0] cmp
);
   // open pin floats mid.
   // The comparators straddle the mid level, so either inner code may appear.
   always_comb begin
      cmp = (level == 2'h0) ? 2'h0 : (level == 2'h2) ? 2'h3 : (jitter ? 2'h2 : 2'h1);
   end
endmodule : scl_strap_model

//--- verif/tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin error_cnt++; \
   $display("unexpected %s exp %h got %h", nm, ex, got); end end

module tb;
   import scl_pkg::*;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic [1:0]  fib = 2'h0;
   logic [1:0]  dup_lvl = 2'h1;
   logic [1:0]  rate_lvl = 2'h1;
   logic        jit = 1'b0;
   logic [4:0]  addr = 5'h00;
   logic        wr_en = 1'b0;
   logic        rd_en = 1'b0;
   logic [15:0] wdata = 16'h0000;
   logic [1:0]  dup_cmp, rate_cmp;
   logic [15:0] rdata, cfg, e, w, v;
   logic        rd_valid, loaded, f_if, f_short, f_long, sd, pass_off;
   logic        fd_off, hd_off, an_off, fixed, low;
   logic [2:0]  qs;
   logic [4:0]  mode;
   int          error_cnt = 0;
   int          cmp_count = 0;
   int          seed = 10;
   int          n;

   always #4 ref_clk = ~ref_clk;

   scl_strap_model dup_m (.level(dup_lvl), .jitter(jit), .cmp(dup_cmp));
   scl_strap_model rate_m (.level(rate_lvl), .jitter(~jit), .cmp(rate_cmp));
   scl_loader DUT (.ref_clk(ref_clk), .rst(rst), .fiber_if_strap(fib),
      .duplex_strap_cmp(dup_cmp), .rate_strap_cmp(rate_cmp), .mgmt_addr(addr),
      .mgmt_wr_en(wr_en), .mgmt_wdata(wdata), .mgmt_rd_en(rd_en), .mgmt_rdata(rdata),
      .mgmt_rd_valid(rd_valid), .straps_loaded(loaded), .cfg_word(cfg),
      .fiber_if_logic_sel(f_if), .short_fiber_sel(f_short), .long_wavelength_sel(f_long),
      .sd_thr_raised(sd), .quant_sens(qs), .passthrough_off(pass_off),
      .adv_full_dup_off(fd_off), .adv_half_dup_off(hd_off), .autoneg_disable(an_off),
      .fixed_rate_sel(fixed), .low_rate_sel(low), .op_mode(mode));

   // ==========================================================================
   // Expectations
   function automatic logic [15:0] exp_cfg(input int f, input int d, input int r);
      logic [15:0] x;
      x = 16'h0000;
      x[7] = (f == 1);
      x[6] = (f == 2);
      x[5] = (f == 3);
      x[11] = (d != 1);
      x[10] = (d == 0);
      x[14] = (r != 1);
      x[9] = (r != 1);
      x[8] = (r == 0);
      return x;
   endfunction : exp_cfg

   function automatic logic [4:0] exp_mode(input logic [15:0] c);
      return c[9] ? (c[8] ? 5'h01 : 5'h02) : !c[11] ? 5'h10 : c[10] ? 5'h04 : 5'h08;
   endfunction : exp_mode

   function automatic logic [4:0] exp_mode_lvl(input int d, input int r);
      return (r == 0) ? 5'h01 : (r == 2) ? 5'h02 : (d == 0) ? 5'h04 : (d == 2) ? 5'h08 : 5'h10;
   endfunction : exp_mode_lvl

   // ==========================================================================
   // Register port tasks
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(negedge ref_clk);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      @(negedge ref_clk);
      wr_en = 1'b0;
   endtask : wr

   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(negedge ref_clk);
      addr = a;
      rd_en = 1'b1;
      @(negedge ref_clk);
      rd_en = 1'b0;
      `CHK("rd_valid", 1'b1, rd_valid)
      d = rdata;
   endtask : rd

   task automatic check_all(input logic [15:0] x);
      logic [15:0] y;
      logic [8:0]  f;
      f = {hd_off, an_off, pass_off, fd_off, fixed, low, f_if, f_long, f_short};
      `CHK("cfg_word", x, cfg)
      `CHK("fields", {x[15:14], x[11:5]}, f)
      `CHK("quant_sens", x[7:5], qs)
      `CHK("sd_thr", x[5], sd)
      `CHK("op_mode", exp_mode(x), mode)
      rd(5'h1e, y);
      `CHK("rdata", x, y)
   endtask : check_all

   task automatic tally_and_finish();
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   // ==========================================================================
   // Sequence: twelve strap settings covering every fiber/duplex pair and every duplex/rate pair, each followed by host traffic
   initial begin
      for (int i = 0; i < 12; i++) begin
         fib = i[1:0];
         dup_lvl = 2'(i % 3);
         rate_lvl = 2'((i / 3) % 3);
         jit = 1'($random(seed));
         rst = 1'b1;
         repeat (3) @(negedge ref_clk);
         rst = 1'b0;
         wr(5'h1e, 16'hffff);
         `CHK("early_cfg", CFG_REG_RESET, cfg)
         `CHK("reset_mode", MODE_RESET, mode)
         n = 2;
         while (loaded !== 1'b1 && n < 400) begin
            @(negedge ref_clk);
            n++;
         end
         `CHK("load_cycles", 251, n)
         fib = ~fib;
         dup_lvl = 2'((dup_lvl + 2'h1) % 3);
         rate_lvl = 2'((rate_lvl + 2'h1) % 3);
         jit = ~jit;
         @(negedge ref_clk);
         e = exp_cfg(i % 4, i % 3, (i / 3) % 3);
         check_all(e);
         `CHK("strap_mode", exp_mode_lvl(i % 3, (i / 3) % 3), mode)
         w = 16'($random(seed));
         wr(5'h1e, w);
         check_all(w);
         wr(5'h1d, ~w);
         rd(5'h1d, v);
         `CHK("unmapped", 16'h0000, v)
         check_all(w);
      end
      tally_and_finish();
   end

   // The run needs about 26 us; the limit leaves ample slack.
   initial begin
      #200000;
      error_cnt++;
      tally_and_finish();
   end
endmodule : tb
